// ### design/fpic_pkg.sv
/*
 Shared constants for the power-down and identification command logic:
 opcodes, identification bytes, bit counts of each command's preamble,
 lane enables and the delay figures with their cycle counts.
 Assumes a 200 MHz core clock that oversamples the serial link.
*/
`default_nettype none
package fpic_pkg;
   // Opcodes
   localparam logic [7:0] OPC_SLEEP_ENTER     = 8'hb9;
   localparam logic [7:0] OPC_SLEEP_RELEASE   = 8'hab;
   localparam logic [7:0] OPC_MAKER_PART      = 8'h90;
   localparam logic [7:0] OPC_MAKER_PART_X2   = 8'h92;
   localparam logic [7:0] OPC_MAKER_PART_X4   = 8'h94;
   localparam logic [7:0] OPC_IDENT           = 8'h9f;
   // Identification bytes; all values are arbitrary
   localparam logic [7:0] MAKER_ID            = 8'h5a;
   localparam logic [7:0] DEVICE_ID           = 8'h13;
   localparam logic [7:0] MEMORY_TYPE         = 8'h40;
   localparam logic [7:0] CAPACITY_CODE       = 8'h14;
   // Bits that follow the opcode before output starts
   localparam logic [5:0] SIG_SKIP_BITS       = 6'h18;
   localparam logic [5:0] MP_SKIP_BITS        = 6'h18;
   localparam logic [5:0] MP_X2_SKIP_BITS     = 6'h20;
   localparam logic [5:0] MP_X4_SKIP_BITS     = 6'h30;
   localparam logic [5:0] ADDR_END_BITS       = 6'h18;
   localparam logic [2:0] OPC_LAST_BIT        = 3'h7;
   // Lane widths and output enables (bit 1 is the single-line output)
   localparam logic [2:0] LANES_X1            = 3'h1;
   localparam logic [2:0] LANES_X2            = 3'h2;
   localparam logic [2:0] LANES_X4            = 3'h4;
   localparam logic [3:0] OE_X1               = 4'h2;
   localparam logic [3:0] OE_X2               = 4'h3;
   localparam logic [3:0] OE_X4               = 4'hf;
   // Delays in ns, rounded up to whole core cycles
   localparam int CLK_PERIOD_NS               = 5;
   localparam int SLEEP_ENTRY_DELAY_NS        = 3000;
   localparam int WAKE_DELAY_NS               = 3000;
   localparam int WAKE_WITH_SIG_DELAY_NS      = 3000;
   localparam int SLEEP_ENTRY_CYC =
      (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC =
      (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_WITH_SIG_CYC =
      (WAKE_WITH_SIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W                     = 16;

   typedef enum {ST_OPC, ST_SKIP, ST_OUT, ST_IGN} fpic_cmd_state_e;
   typedef enum {PS_STANDBY, PS_ENTER, PS_SLEEP, PS_WAKE} fpic_pwr_state_e;
endpackage
`default_nettype wire

// ### design/fpic_sync.sv
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes the inputs are independent levels; no word coherence is given.
*/
`default_nettype none
module fpic_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [5:0] RESET_VAL = 6'h00
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   // Levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r  <= RESET_VAL[WIDTH-1:0];
         syncOut <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ### design/fpic_cmd.sv
/*
 Serial flash command logic for sleep entry and release and for the
 identification reads, oversampling the link pins with the core clock.
 Assumes the serial clock is well below a quarter of ref_clk and that
 write-in-progress and quad-enable come from logic on ref_clk.
*/
`default_nettype none
// Behaviour
// - Only the sleep-entry opcode can put the device to sleep.
// - While asleep, every opcode except release is ignored.
// - Chip select high with no cycle running means standby.
// - Sleep entry executes only if select rises right after bit eight.
// - Sleep is reached a fixed entry delay after select rises.
// - Sleep entry during a write cycle is rejected, cycle untouched.
// - Power-up (reset) always lands in standby, never asleep.
// - Bare release wakes after the wake delay; commands blocked meanwhile.
// - Release plus three dummy bytes streams the device ID repeatedly.
// - Wake with signature read takes its own wake delay, equal to the bare one by default.
// - Signature read works asleep or awake when no write cycle runs.
// - Release during a write cycle is not decoded at all.
// - Single-line maker/part read: two dummies, address, then IDs.
// - Address bit zero picks which ID comes first; IDs alternate.
// - Dual-line maker/part read uses two lanes and a mode byte.
// - Quad maker/part read accepted only with quad enable set.
// - Quad read adds mode byte and two dummies on four lanes.
// - Identification read sends maker, memory type, capacity bytes.
// - Select rising ends any read and returns to standby.
// - Identification read during a write cycle is not decoded.
// - Write-in-progress status mirrors the running self-timed cycle.
module fpic_cmd #(
   parameter int SLEEP_ENTRY_CYC   = fpic_pkg::SLEEP_ENTRY_CYC,
   parameter int WAKE_CYC          = fpic_pkg::WAKE_CYC,
   parameter int WAKE_WITH_SIG_CYC = fpic_pkg::WAKE_WITH_SIG_CYC
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Serial link pins
   input  wire logic       chipSelN,
   input  wire logic       serialClk,
   input  wire logic [3:0] ioIn,
   output logic      [3:0] ioOut,
   output logic      [3:0] ioOe,
   // Device status in
   input  wire logic       writeInProgress,
   input  wire logic       quadEnable,
   // Device status out
   output logic            writeInProgressBit,
   output logic            deepSleep,
   output logic            standby
);
   localparam int TW = fpic_pkg::TIMER_W;

   logic [5:0]                syncQ;
   logic                      csS, sclkS, csPrev_r, sclkPrev_r;
   logic [3:0]                ioS;
   logic                      csRise, csHigh, sclkRise, sclkFall;
   fpic_pkg::fpic_cmd_state_e state_r;
   fpic_pkg::fpic_pwr_state_e pwr_r;
   logic [TW-1:0]             timer_r;
   logic [5:0]                cnt_r, cntNxt, skip_r;
   logic [2:0]                width_r;
   logic [7:0]                inSr_r, opcNext, inNxt;
   logic                      p16_r, isMp_r, addrSel_r, first_r;
   logic [23:0]               outSr_r, loadVal, present;
   logic                      sleepCand_r, wakeReq_r, sigRead_r;
   logic                      blocked, inSleep, opcDone, opcOk, goOut;
   logic                      addrNow, selNow, enterOk;

   function automatic logic [7:0] shiftIn(input logic [7:0] sr,
                                          input logic [3:0] io,
                                          input logic [2:0] w);
      logic [7:0] r;
      r = {sr[6:0], io[0]};
      if (w == fpic_pkg::LANES_X2)
         r = {sr[5:0], io[1:0]};
      else if (w == fpic_pkg::LANES_X4)
         r = {sr[3:0], io[3:0]};
      return r;
   endfunction

   // Rotation over 16 bits gives the two-byte alternation
   function automatic logic [23:0] rotOut(input logic [23:0] sr,
                                          input logic [2:0]  w,
                                          input logic        p16);
      logic [23:0] r;
      r = {sr[22:0], sr[23]};
      if (p16) begin
         if (w == fpic_pkg::LANES_X4)
            r = {sr[19:8], sr[23:20], sr[7:0]};
         else if (w == fpic_pkg::LANES_X2)
            r = {sr[21:8], sr[23:22], sr[7:0]};
         else
            r = {sr[22:8], sr[23], sr[7:0]};
      end else if (w == fpic_pkg::LANES_X4) begin
         r = {sr[19:0], sr[23:20]};
      end else if (w == fpic_pkg::LANES_X2) begin
         r = {sr[21:0], sr[23:22]};
      end
      return r;
   endfunction

   // Chip select resets high so a reset never looks like a selection
   fpic_sync #(
      .WIDTH     (6),
      .RESET_VAL (6'h20)
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .asyncIn ({chipSelN, serialClk, ioIn}),
      .syncOut (syncQ)
   );

   assign csS   = syncQ[5];
   assign sclkS = syncQ[4];
   assign ioS   = syncQ[3:0];

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         csPrev_r   <= 1'b1;
         sclkPrev_r <= 1'b0;
      end else begin
         csPrev_r   <= csS;
         sclkPrev_r <= sclkS;
      end
   end

   assign csRise   = csS & ~csPrev_r;
   assign csHigh   = csS;
   assign sclkRise = sclkS & ~sclkPrev_r & ~csS;
   assign sclkFall = ~sclkS & sclkPrev_r & ~csS;

   assign inSleep = (pwr_r == fpic_pkg::PS_SLEEP);
   assign blocked = (pwr_r == fpic_pkg::PS_ENTER) ||
                    (pwr_r == fpic_pkg::PS_WAKE);
   assign opcDone = sclkRise && (state_r == fpic_pkg::ST_OPC) &&
                    (cnt_r[2:0] == fpic_pkg::OPC_LAST_BIT);
   assign opcNext = {inSr_r[6:0], ioS[0]};
   assign inNxt   = shiftIn(inSr_r, ioS, width_r);
   assign cntNxt  = 6'(cnt_r + {3'h0, width_r});
   assign enterOk = !blocked && !inSleep && !writeInProgress;
   assign addrNow = isMp_r && (cntNxt == fpic_pkg::ADDR_END_BITS);
   assign selNow  = addrNow ? inNxt[0] : addrSel_r;

   // Opcode acceptance
   always_comb begin
      case (opcNext)
         fpic_pkg::OPC_SLEEP_RELEASE:
            opcOk = !blocked && !writeInProgress;
         fpic_pkg::OPC_MAKER_PART, fpic_pkg::OPC_MAKER_PART_X2,
         fpic_pkg::OPC_IDENT:
            opcOk = enterOk;
         fpic_pkg::OPC_MAKER_PART_X4:
            opcOk = enterOk && quadEnable;
         default:
            opcOk = 1'b0;
      endcase
   end

   assign goOut = (opcDone && opcOk && opcNext == fpic_pkg::OPC_IDENT) ||
                  (sclkRise && state_r == fpic_pkg::ST_SKIP &&
                   cntNxt == skip_r);

   always_comb begin
      if (state_r == fpic_pkg::ST_OPC)
         loadVal = {fpic_pkg::MAKER_ID, fpic_pkg::MEMORY_TYPE,
                    fpic_pkg::CAPACITY_CODE};
      else if (!isMp_r)
         loadVal = {3{fpic_pkg::DEVICE_ID}};
      else if (selNow)
         loadVal = {fpic_pkg::DEVICE_ID, fpic_pkg::MAKER_ID, 8'h00};
      else
         loadVal = {fpic_pkg::MAKER_ID, fpic_pkg::DEVICE_ID, 8'h00};
   end

   // Command sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= fpic_pkg::ST_OPC;
         cnt_r     <= 6'h00;
         skip_r    <= 6'h00;
         width_r   <= fpic_pkg::LANES_X1;
         p16_r     <= 1'b0;
         isMp_r    <= 1'b0;
         addrSel_r <= 1'b0;
      end else if (csHigh) begin
         state_r <= fpic_pkg::ST_OPC;
         cnt_r   <= 6'h00;
         width_r <= fpic_pkg::LANES_X1;
      end else if (opcDone) begin
         cnt_r   <= 6'h00;
         p16_r   <= 1'b0;
         isMp_r  <= 1'b0;
         width_r <= fpic_pkg::LANES_X1;
         if (!opcOk) begin
            state_r <= fpic_pkg::ST_IGN;
         end else if (opcNext == fpic_pkg::OPC_IDENT) begin
            state_r <= fpic_pkg::ST_OUT;
         end else begin
            state_r <= fpic_pkg::ST_SKIP;
            case (opcNext)
               fpic_pkg::OPC_MAKER_PART: begin
                  skip_r <= fpic_pkg::MP_SKIP_BITS;
                  p16_r  <= 1'b1;
                  isMp_r <= 1'b1;
               end
               fpic_pkg::OPC_MAKER_PART_X2: begin
                  skip_r  <= fpic_pkg::MP_X2_SKIP_BITS;
                  width_r <= fpic_pkg::LANES_X2;
                  p16_r   <= 1'b1;
                  isMp_r  <= 1'b1;
               end
               fpic_pkg::OPC_MAKER_PART_X4: begin
                  skip_r  <= fpic_pkg::MP_X4_SKIP_BITS;
                  width_r <= fpic_pkg::LANES_X4;
                  p16_r   <= 1'b1;
                  isMp_r  <= 1'b1;
               end
               default:
                  skip_r <= fpic_pkg::SIG_SKIP_BITS;
            endcase
         end
      end else if (sclkRise) begin
         if (state_r == fpic_pkg::ST_OPC)
            cnt_r <= 6'(cnt_r + 6'h01);
         else if (state_r == fpic_pkg::ST_SKIP) begin
            cnt_r <= cntNxt;
            if (addrNow)
               addrSel_r <= inNxt[0];
            if (cntNxt == skip_r)
               state_r <= fpic_pkg::ST_OUT;
         end
      end
   end

   // Input shifter, MSB first; the mode byte is taken but not checked
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         inSr_r <= 8'h00;
      else if (sclkRise && state_r == fpic_pkg::ST_SKIP)
         inSr_r <= inNxt;
      else if (sclkRise)
         inSr_r <= opcNext;
   end

   // Output shifter: data leaves on falling clock edges
   assign present = first_r ? outSr_r : rotOut(outSr_r, width_r, p16_r);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         outSr_r <= 24'h000000;
         first_r <= 1'b0;
         ioOut   <= 4'h0;
         ioOe    <= 4'h0;
      end else if (csHigh) begin
         first_r <= 1'b0;
         ioOe    <= 4'h0;
      end else if (goOut) begin
         outSr_r <= loadVal;
         first_r <= 1'b1;
      end else if (sclkFall && state_r == fpic_pkg::ST_OUT) begin
         outSr_r <= present;
         first_r <= 1'b0;
         if (width_r == fpic_pkg::LANES_X4) begin
            ioOut <= present[23:20];
            ioOe  <= fpic_pkg::OE_X4;
         end else if (width_r == fpic_pkg::LANES_X2) begin
            ioOut <= {2'h0, present[23:22]};
            ioOe  <= fpic_pkg::OE_X2;
         end else begin
            ioOut <= {2'h0, present[23], 1'b0};
            ioOe  <= fpic_pkg::OE_X1;
         end
      end
   end

   // Frame flags for the power sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sleepCand_r <= 1'b0;
         wakeReq_r   <= 1'b0;
         sigRead_r   <= 1'b0;
      end else if (csHigh) begin
         sleepCand_r <= 1'b0;
         wakeReq_r   <= 1'b0;
         sigRead_r   <= 1'b0;
      end else if (opcDone) begin
         sleepCand_r <= (opcNext == fpic_pkg::OPC_SLEEP_ENTER) &&
                        enterOk;
         wakeReq_r   <= (opcNext == fpic_pkg::OPC_SLEEP_RELEASE) &&
                        opcOk && inSleep;
      end else if (sclkRise) begin
         sleepCand_r <= 1'b0;
         sigRead_r   <= wakeReq_r;
      end
   end

   // Power sequencer; reset is power-up and lands in standby
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_r   <= fpic_pkg::PS_STANDBY;
         timer_r <= '0;
      end else begin
         unique case (pwr_r)
            fpic_pkg::PS_STANDBY: begin
               if (csRise && sleepCand_r) begin
                  pwr_r   <= fpic_pkg::PS_ENTER;
                  timer_r <= TW'(SLEEP_ENTRY_CYC - 1);
               end
            end
            fpic_pkg::PS_ENTER: begin
               if (timer_r == '0)
                  pwr_r <= fpic_pkg::PS_SLEEP;
               else
                  timer_r <= TW'(timer_r - 1'b1);
            end
            fpic_pkg::PS_SLEEP: begin
               if (csRise && wakeReq_r) begin
                  pwr_r   <= fpic_pkg::PS_WAKE;
                  timer_r <= sigRead_r ? TW'(WAKE_WITH_SIG_CYC - 1)
                                       : TW'(WAKE_CYC - 1);
               end
            end
            fpic_pkg::PS_WAKE: begin
               if (timer_r == '0)
                  pwr_r <= fpic_pkg::PS_STANDBY;
               else
                  timer_r <= TW'(timer_r - 1'b1);
            end
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         writeInProgressBit <= 1'b0;
         deepSleep          <= 1'b0;
         standby            <= 1'b0;
      end else begin
         writeInProgressBit <= writeInProgress;
         deepSleep          <= inSleep;
         standby            <= csS && !writeInProgress &&
                               pwr_r == fpic_pkg::PS_STANDBY;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   property p_sleepOnlyByOpcode;
      $rose(pwr_r == fpic_pkg::PS_ENTER) |-> $past(csRise && sleepCand_r);
   endproperty
   a_sleepOnlyByOpcode: assert property (p_sleepOnlyByOpcode)
      else $error("sleep entered without sleep opcode");

   property p_sleepIgnores;
      opcDone && inSleep && opcNext != fpic_pkg::OPC_SLEEP_RELEASE
      |=> state_r == fpic_pkg::ST_IGN;
   endproperty
   a_sleepIgnores: assert property (p_sleepIgnores)
      else $error("command decoded while asleep");

   property p_candDropsOnExtraClock;
      sleepCand_r && sclkRise |=> !sleepCand_r;
   endproperty
   a_candDropsOnExtraClock: assert property (p_candDropsOnExtraClock)
      else $error("sleep command kept after extra clock");

   property p_entryDelay;
      pwr_r == fpic_pkg::PS_ENTER |=>
         (pwr_r == fpic_pkg::PS_SLEEP && $past(timer_r) == '0) ||
         (pwr_r == fpic_pkg::PS_ENTER &&
          timer_r == TW'($past(timer_r) - 1'b1));
   endproperty
   a_entryDelay: assert property (p_entryDelay)
      else $error("sleep entry delay miscounted");

   property p_sleepRejectedInCycle;
      opcDone && writeInProgress |=> !sleepCand_r;
   endproperty
   a_sleepRejectedInCycle: assert property (p_sleepRejectedInCycle)
      else $error("sleep accepted during write cycle");

   property p_wakeFromSleep;
      $rose(pwr_r == fpic_pkg::PS_WAKE) |-> $past(inSleep && wakeReq_r);
   endproperty
   a_wakeFromSleep: assert property (p_wakeFromSleep)
      else $error("wake without release in sleep");

   property p_releaseIgnoredBusy;
      opcDone && writeInProgress |=> state_r == fpic_pkg::ST_IGN;
   endproperty
   a_releaseIgnoredBusy: assert property (p_releaseIgnoredBusy)
      else $error("command decoded during write cycle");

   property p_quadNeedsEnable;
      opcDone && opcNext == fpic_pkg::OPC_MAKER_PART_X4 && !quadEnable
      |=> state_r == fpic_pkg::ST_IGN;
   endproperty
   a_quadNeedsEnable: assert property (p_quadNeedsEnable)
      else $error("quad read accepted without quad enable");

   property p_singleLaneOut;
      sclkFall && state_r == fpic_pkg::ST_OUT &&
      width_r == fpic_pkg::LANES_X1 |=> ioOe == fpic_pkg::OE_X1;
   endproperty
   a_singleLaneOut: assert property (p_singleLaneOut)
      else $error("single-line output enable wrong");

   property p_deselectEnds;
      csRise |=> state_r == fpic_pkg::ST_OPC && ioOe == 4'h0;
   endproperty
   a_deselectEnds: assert property (p_deselectEnds)
      else $error("read not ended by deselect");

   c_sleepEntered: cover property ($rose(inSleep));
   c_wakeDone: cover property (pwr_r == fpic_pkg::PS_WAKE ##1
                               pwr_r == fpic_pkg::PS_STANDBY);
   c_quadOut: cover property (ioOe == fpic_pkg::OE_X4);
   c_dualOut: cover property (ioOe == fpic_pkg::OE_X2);
endmodule
`default_nettype wire

// ### tb/fpic_host.sv
/*
 Host model of the serial link: frames a command, clocks the link and
 collects the answer lanes. Assumes the bench's ref_clk; each link clock
 is high 8 and low 16 ref_clk cycles, so the link clock period is 120 ns.
*/
`default_nettype none
module fpic_host (
   // Core clock
   input  wire logic       ref_clk,
   // Link pins
   output logic            chipSelN,
   output logic            serialClk,
   output logic      [3:0] ioIn,
   input  wire logic [3:0] ioOut,
   input  wire logic [3:0] ioOe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      chipSelN = 1'b1;
      serialClk = 1'b0;
      ioIn = 4'ha;
   end

   // Opcode on io0, the rest on the command's lanes, MSB first
   task automatic frame(input logic [55:0] tx, input int txBits,
                        input int lanes, input int rxBits,
                        output logic [31:0] rx, output logic oeAny);
      int txClk;
      int n;
      int w;
      txClk = 8 + (txBits - 8) / lanes;
      n = rxBits / lanes;
      rx = '0;
      oeAny = 1'b0;
      @(posedge ref_clk);
      chipSelN <= 1'b0;
      for (int i = 0; i < txClk + n; i++) begin
         repeat (8) @(posedge ref_clk);
         oeAny = oeAny | (|ioOe);
         if (i >= txClk) begin
            case (lanes)
               1: rx = {rx[30:0], ioOut[1]};
               2: rx = {rx[29:0], ioOut[1:0]};
               default: rx = {rx[27:0], ioOut};
            endcase
         end
         w = (i < 8) ? 1 : lanes;
         // Idle lanes toggle so a stale level never reads as data
         case (w)
            1: ioIn <= {~ioIn[3:1], tx[55]};
            2: ioIn <= {~ioIn[3:2], tx[55:54]};
            default: ioIn <= tx[55:52];
         endcase
         tx = tx << w;
         repeat (8) @(posedge ref_clk);
         serialClk <= 1'b1;
         repeat (8) @(posedge ref_clk);
         serialClk <= 1'b0;
      end
      // Select rises right after the last falling edge
      repeat (8) @(posedge ref_clk);
      chipSelN <= 1'b1;
      ioIn <= ~ioIn;
   endtask
endmodule
`default_nettype wire

// ### tb/fpic_cmd_tb.sv
/*
 Self-checking bench for the power-down and identification command logic.
 Assumes the host model in fpic_host.sv and shortened delay parameters.
*/
`default_nettype none
module fpic_cmd_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 20;
   // Longer wake after a signature read, so a swapped delay shows
   localparam int DLY2 = 40;
   localparam logic [7:0] M = fpic_pkg::MAKER_ID;
   localparam logic [7:0] D = fpic_pkg::DEVICE_ID;
   logic        ref_clk, resetn, chipSelN, serialClk, oe;
   logic        writeInProgress, quadEnable, writeInProgressBit;
   logic        deepSleep, standby;
   logic [3:0]  ioIn, ioOut, ioOe;
   logic [31:0] rx;
   int          errors = 0;
   int          check_count = 0;

   fpic_cmd #(.SLEEP_ENTRY_CYC(DLY), .WAKE_CYC(DLY),
              .WAKE_WITH_SIG_CYC(DLY2)) fpic_cmd_inst (
      .ref_clk(ref_clk), .resetn(resetn), .chipSelN(chipSelN),
      .serialClk(serialClk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
      .writeInProgress(writeInProgress), .quadEnable(quadEnable),
      .writeInProgressBit(writeInProgressBit), .deepSleep(deepSleep),
      .standby(standby));
   fpic_host fpic_host_inst (
      .ref_clk(ref_clk), .chipSelN(chipSelN), .serialClk(serialClk),
      .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic go(input logic [55:0] tx, input int b, l, r);
      fpic_host_inst.frame(tx, b, l, r, rx, oe);
   endtask

   task automatic t_ident;
      go({8'h9f, 48'h0}, 8, 1, 32);
      check("ident", rx, {M, fpic_pkg::MEMORY_TYPE,
            fpic_pkg::CAPACITY_CODE, M});
      idle(8);
      check("oe after ident", ioOe, 4'h0);
      check("standby", standby, 1'b1);
   endtask

   task automatic t_maker_part;
      logic [7:0] a;
      for (int k = 0; k < 6; k++) begin
         a = 8'(k % 2);
         case (k / 2)
            0: go({8'h90, 16'h0, a, 24'h0}, 32, 1, 32);
            1: go({8'h92, 16'h0, a, 8'h20, 16'h0}, 40, 2, 32);
            default: go({8'h94, 16'h0, a, 8'h20, 16'h0}, 56, 4, 32);
         endcase
         check("maker part", rx, a[0] ? {D, M, D, M} : {M, D, M, D});
         idle(8);
      end
      quadEnable <= 1'b0;
      go({8'h94, 16'h0, 8'h0, 8'h20, 16'h0}, 56, 4, 32);
      check("quad off", oe, 1'b0);
      quadEnable <= 1'b1;
   endtask

   task automatic t_sleep;
      go({8'hb9, 48'h0}, 8, 1, 0);
      idle(14);
      check("entering", deepSleep, 1'b0);
      idle(14);
      check("asleep", {deepSleep, standby}, 2'b10);
      go({8'h90, 48'h0}, 32, 1, 16);
      check("ignored asleep", oe, 1'b0);
      go({8'hab, 48'h0}, 8, 1, 0);
      idle(4);
      check("waking", standby, 1'b0);
      idle(DLY + 8);
      check("woken", {deepSleep, standby}, 2'b01);
   endtask

   task automatic t_signature;
      go({8'hab, 48'h0}, 32, 1, 16);
      check("sig awake", rx, {D, D});
      idle(8);
      check("sig standby", standby, 1'b1);
      go({8'hb9, 48'h0}, 8, 1, 0);
      idle(DLY + 8);
      go({8'hab, 48'h0}, 32, 1, 16);
      check("sig asleep", rx, {D, D});
      idle(4);
      check("sig waking", standby, 1'b0);
      idle(DLY + 8);
      check("sig long wake", standby, 1'b0);
      idle(DLY2 - DLY + 4);
      check("sig woken", {deepSleep, standby}, 2'b01);
   endtask

   task automatic t_refused;
      go({8'hb9, 48'h0}, 9, 1, 0);
      idle(DLY + 8);
      check("late select", deepSleep, 1'b0);
      writeInProgress <= 1'b1;
      idle(3);
      check("wip bit", {writeInProgressBit, standby}, 2'b10);
      go({8'hb9, 48'h0}, 8, 1, 0);
      go({8'hab, 48'h0}, 32, 1, 16);
      check("sig busy", oe, 1'b0);
      go({8'h9f, 48'h0}, 8, 1, 16);
      check("ident busy", oe, 1'b0);
      idle(DLY + 8);
      check("sleep busy", deepSleep, 1'b0);
      writeInProgress <= 1'b0;
      idle(4);
      check("wip done", {writeInProgressBit, standby}, 2'b01);
   endtask

   task automatic t_reset;
      go({8'hb9, 48'h0}, 8, 1, 0);
      idle(DLY + 8);
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      idle(4);
      check("after reset", {deepSleep, standby}, 2'b01);
   endtask

   task automatic wrap_up;
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #300us;
      errors++;
      wrap_up();
   end

   initial begin
      resetn = 1'b0;
      writeInProgress = 1'b0;
      quadEnable = 1'b1;
      idle(8);
      resetn <= 1'b1;
      idle(4);
      t_ident();
      t_maker_part();
      t_sleep();
      t_signature();
      t_refused();
      t_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
